/* logic/efc_params.svh */
// Register offsets, field positions, reset values and sizes of the FIFO controller
`ifndef EFC_PARAMS_SVH
`define EFC_PARAMS_SVH

// ----------------------------------------
// Physical memory block
// ----------------------------------------
`define EFC_DEPTH 10'h200
`define EFC_AW 9
`define EFC_DW 9
`define EFC_CW 10

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EFC_OFS_CTRL 8'h00
`define EFC_OFS_THRESH 8'h04
`define EFC_OFS_STATUS 8'h08
`define EFC_OFS_MASK 8'h0c
`define EFC_OFS_LEVEL 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EFC_CTRL_MODE_LSB 0
`define EFC_CTRL_WRAP_WR 3
`define EFC_CTRL_WRAP_RD 4
`define EFC_THR_AF_LSB 0
`define EFC_THR_AE_LSB 16
`define EFC_NUM_EV 6

// ----------------------------------------
// Reset values and fixed thresholds
// ----------------------------------------
`define EFC_CTRL_RST 32'h0000_0001
`define EFC_THR_AF_RST 10'h1f0
`define EFC_THR_AE_RST 10'h010
`define EFC_FIX_AF 10'h1c0
`define EFC_FIX_AE 10'h040

`endif

/* logic/efc_pkg.sv */
// Types shared by the FIFO controller, its user logic and the bench
package efc_pkg;

  // ----------------------------------------
  // Flag modes, one-hot
  // ----------------------------------------
  typedef enum logic [2:0] {
    EFC_FLAGS_NONE = 3'b001,
    EFC_FLAGS_FIXED = 3'b010,
    EFC_FLAGS_REG = 3'b100
  } efc_mode_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic push;
    logic [8:0] data;
  } efc_wr_t;

  typedef struct packed {
    logic full;
    logic empty;
    logic afull;
    logic aempty;
  } efc_flags_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } efc_bus_t;

  typedef struct packed {
    logic load;
    logic [9:0] afull;
    logic [9:0] aempty;
  } efc_thr_t;

  // ----------------------------------------
  // Whole state of the controller
  // ----------------------------------------
  typedef struct packed {
    logic [8:0] wr_ptr;
    logic [8:0] rd_ptr;
    logic [9:0] count;
    efc_flags_t flags;
    efc_mode_t mode;
    logic wrap_wr;
    logic wrap_rd;
    logic [9:0] thr_af;
    logic [9:0] thr_ae;
    logic [5:0] status;
    logic [5:0] mask;
    logic [31:0] rdata;
    logic irq;
    logic rd_valid;
  } efc_state_t;

endpackage

/* logic/efc_mem.sv */
// Storage array of the FIFO with a registered read port
`timescale 1ns/1ps
`include "efc_params.svh"

module efc_mem (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [`EFC_AW-1:0] wr_addr,
  input wire logic [`EFC_DW-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [`EFC_AW-1:0] rd_addr,
  output logic [`EFC_DW-1:0] rd_data_r
);

  logic [`EFC_DW-1:0] mem [0:(1<<`EFC_AW)-1];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data_r <= 9'h000;
    end else if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end

endmodule

/* logic/efc_fifo.sv */
// FIFO controller: flag modes, counter wrap options, register port and interrupt
// What this block does
// - Three flag modes: none, fixed, register
// - Fixed thresholds are constants, never changed
// - Register thresholds reload at run time
// - Write wrap: counter rolls, writes keep storing
// - Read wrap: counter rolls, old data replayed
// - Full flag follows the physical depth
// - One shared clock for the read and write sides
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "efc_params.svh"

module efc_fifo (
  input wire logic mclk,
  input wire logic rst,
  input wire efc_pkg::efc_wr_t wr_req,
  input wire logic rd_en,
  input wire efc_pkg::efc_thr_t tp_thr,
  input wire efc_pkg::efc_bus_t bus,
  output logic [31:0] bus_rdata,
  output logic [8:0] rd_data,
  output logic rd_valid,
  output efc_pkg::efc_flags_t flags,
  output logic irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  efc_pkg::efc_state_t q_r;
  efc_pkg::efc_state_t q_nxt;

  logic rd_real;
  logic wr_take;
  logic rd_take;
  logic cnt_up;
  logic [9:0] af_lvl;
  logic [9:0] ae_lvl;
  logic [5:0] events;
  logic [8:0] mem_q;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] ofs);
    sel = (a == ofs);
  endfunction

  function automatic efc_pkg::efc_flags_t flag_calc(input logic [9:0] cnt, input efc_pkg::efc_mode_t m,
                                                   input logic [9:0] af, input logic [9:0] ae);
    efc_pkg::efc_flags_t f;
    f.full = (cnt == `EFC_DEPTH);
    f.empty = (cnt == 10'h000);
    f.afull = (m != efc_pkg::EFC_FLAGS_NONE) && (cnt >= af);
    f.aempty = (m != efc_pkg::EFC_FLAGS_NONE) && (cnt <= ae);
    return f;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    q_nxt = q_r;
    rd_real = rd_en && (q_r.count != 10'h000);
    wr_take = wr_req.push && ((q_r.count != `EFC_DEPTH) || rd_real || q_r.wrap_wr);
    rd_take = rd_en && ((q_r.count != 10'h000) || q_r.wrap_rd);
    cnt_up = wr_take && ((q_r.count != `EFC_DEPTH) || rd_real);

    if (wr_take) begin
      q_nxt.wr_ptr = q_r.wr_ptr + 9'h001;
    end
    if (rd_take) begin
      q_nxt.rd_ptr = q_r.rd_ptr + 9'h001;
    end
    if (cnt_up && !rd_real) begin
      q_nxt.count = q_r.count + 10'h001;
    end else if (!cnt_up && rd_real) begin
      q_nxt.count = q_r.count - 10'h001;
    end
    q_nxt.rd_valid = rd_take;

    unique case (q_r.mode)
      efc_pkg::EFC_FLAGS_FIXED: begin
        af_lvl = `EFC_FIX_AF;
        ae_lvl = `EFC_FIX_AE;
      end
      efc_pkg::EFC_FLAGS_REG: begin
        af_lvl = q_r.thr_af;
        ae_lvl = q_r.thr_ae;
      end
      default: begin
        af_lvl = `EFC_DEPTH;
        ae_lvl = 10'h000;
      end
    endcase
    q_nxt.flags = flag_calc(q_nxt.count, q_r.mode, af_lvl, ae_lvl);

    // Rising flags and refused accesses are the interrupt events
    events = {rd_en && !rd_take,
              wr_req.push && !wr_take,
              q_nxt.flags.aempty && !q_r.flags.aempty,
              q_nxt.flags.afull && !q_r.flags.afull,
              q_nxt.flags.empty && !q_r.flags.empty,
              q_nxt.flags.full && !q_r.flags.full};

    // Register writes
    if (bus.wr) begin
      if (sel(bus.addr, `EFC_OFS_CTRL)) begin
        unique case (bus.wdata[`EFC_CTRL_MODE_LSB +: 3])
          3'b010: q_nxt.mode = efc_pkg::EFC_FLAGS_FIXED;
          3'b100: q_nxt.mode = efc_pkg::EFC_FLAGS_REG;
          default: q_nxt.mode = efc_pkg::EFC_FLAGS_NONE;
        endcase
        q_nxt.wrap_wr = bus.wdata[`EFC_CTRL_WRAP_WR];
        q_nxt.wrap_rd = bus.wdata[`EFC_CTRL_WRAP_RD];
      end
      if (sel(bus.addr, `EFC_OFS_MASK)) begin
        q_nxt.mask = bus.wdata[5:0];
      end
    end
    // thresholds from bus or test port
    if (bus.wr && sel(bus.addr, `EFC_OFS_THRESH)) begin
      q_nxt.thr_af = bus.wdata[`EFC_THR_AF_LSB +: 10];
      q_nxt.thr_ae = bus.wdata[`EFC_THR_AE_LSB +: 10];
    end else if (tp_thr.load) begin
      q_nxt.thr_af = tp_thr.afull;
      q_nxt.thr_ae = tp_thr.aempty;
    end

    // Register reads, answer stands one cycle only
    q_nxt.rdata = 32'h0000_0000;
    if (bus.rd) begin
      if (sel(bus.addr, `EFC_OFS_CTRL)) begin
        q_nxt.rdata = {27'h000_0000, q_r.wrap_rd, q_r.wrap_wr, q_r.mode};
      end else if (sel(bus.addr, `EFC_OFS_THRESH)) begin
        q_nxt.rdata = {6'h00, q_r.thr_ae, 6'h00, q_r.thr_af};
      end else if (sel(bus.addr, `EFC_OFS_STATUS)) begin
        q_nxt.rdata = {26'h000_0000, q_r.status};
      end else if (sel(bus.addr, `EFC_OFS_MASK)) begin
        q_nxt.rdata = {26'h000_0000, q_r.mask};
      end else if (sel(bus.addr, `EFC_OFS_LEVEL)) begin
        q_nxt.rdata = {22'h00_0000, q_r.count};
      end
    end

    // Set wins over read-clear so no event is lost
    for (int i = 0; i < `EFC_NUM_EV; i++) begin
      if (events[i]) begin
        q_nxt.status[i] = 1'b1;
      end else if (bus.rd && sel(bus.addr, `EFC_OFS_STATUS)) begin
        q_nxt.status[i] = 1'b0;
      end
    end
    q_nxt.irq = |(q_nxt.status & q_nxt.mask);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q_r <= '{wr_ptr: 9'h000, rd_ptr: 9'h000, count: 10'h000,
               flags: '{full: 1'b0, empty: 1'b1, afull: 1'b0, aempty: 1'b0},
               mode: efc_pkg::EFC_FLAGS_NONE, wrap_wr: 1'b0, wrap_rd: 1'b0,
               thr_af: `EFC_THR_AF_RST, thr_ae: `EFC_THR_AE_RST,
               status: 6'h00, mask: 6'h00, rdata: 32'h0000_0000, irq: 1'b0, rd_valid: 1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------
  // Memory
  // ----------------------------------------
  // one clock drives both sides here
  efc_mem u_mem (
    .mclk(mclk),
    .rst(rst),
    .wr_en(wr_take),
    .wr_addr(q_r.wr_ptr),
    .wr_data(wr_req.data),
    .rd_en(rd_take),
    .rd_addr(q_r.rd_ptr),
    .rd_data_r(mem_q)
  );

  assign rd_data = mem_q;
  assign rd_valid = q_r.rd_valid;
  assign flags = q_r.flags;
  assign irq = q_r.irq;
  assign bus_rdata = q_r.rdata;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence full_no_wrap_s;
    q_r.count == `EFC_DEPTH && !q_r.wrap_wr && wr_req.push && !rd_en;
  endsequence

  sequence empty_no_wrap_s;
    q_r.count == 10'h000 && !q_r.wrap_rd && rd_en;
  endsequence

  full_flag_a: assert property (q_r.flags.full == (q_r.count == 10'h200))
    else $error("full flag not tied to physical depth");
  wr_block_a: assert property (full_no_wrap_s |=> $stable(q_r.wr_ptr) && q_r.status[4])
    else $error("write into full fifo not refused");
  wr_wrap_a: assert property (q_r.wrap_wr && wr_req.push |=> q_r.wr_ptr == $past(q_r.wr_ptr) + 9'h001)
    else $error("wrapping write counter did not advance");
  rd_block_a: assert property (empty_no_wrap_s |=> $stable(q_r.rd_ptr) && !rd_valid)
    else $error("read from empty fifo not refused");
  // A push in the same cycle may still raise the level by one
  rd_wrap_a: assert property (q_r.wrap_rd && rd_en |=> rd_valid && q_r.count <= $past(q_r.count) + 10'h001)
    else $error("wrapping read did not replay data");
  none_flags_a: assert property (q_r.mode == efc_pkg::EFC_FLAGS_NONE |=> !q_r.flags.afull)
    else $error("threshold flag raised with no flags");
  fixed_thr_a: assert property (q_r.mode == efc_pkg::EFC_FLAGS_FIXED && $stable(q_r.mode)
                                |-> q_r.flags.afull == (q_r.count >= 10'h1c0))
    else $error("fixed threshold not applied");
  thr_load_a: assert property (tp_thr.load && !bus.wr |=> q_r.thr_af == $past(tp_thr.afull))
    else $error("test port threshold load lost");
  irq_level_a: assert property (irq == |(q_r.status & q_r.mask))
    else $error("interrupt does not follow masked status");

endmodule

/* tb/efc_user.sv */
// Producer and consumer user logic beside the FIFO
`timescale 1ns/1ps
module efc_user (
  input wire logic mclk,
  input wire logic rst,
  input wire logic go_wr,
  input wire logic go_rd,
  input wire logic [8:0] din,
  output efc_pkg::efc_wr_t wr_req,
  output logic rd_en
);
  // One block, far under the cascade limit
  localparam int BLOCKS_USED = 1;
  // Same 9-bit shape on both sides
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_req <= '0;
      rd_en <= 1'b0;
    end else begin
      // Idle data inverted, so a stale word never looks valid
      wr_req.data <= go_wr ? din : ~wr_req.data;
      wr_req.push <= go_wr;
      rd_en <= go_rd;
    end
  end
endmodule

/* tb/tb_efc_fifo.sv */
// Self-checking bench for the FIFO controller
`timescale 1ns/1ps
module tb_efc_fifo;
  logic mclk, rst, go_wr, go_rd, irq, rd_valid, rd_en, wrap_w, wrap_r, brd;
  logic [8:0] din, rd_data, wp, rp;
  logic [8:0] mem [512];
  logic [31:0] bus_rdata;
  logic [63:0] be;
  efc_pkg::efc_bus_t bus;
  efc_pkg::efc_thr_t tp;
  efc_pkg::efc_wr_t wr_req;
  efc_pkg::efc_flags_t flags;
  logic [8:0] q[$];
  logic [63:0] bq[$];
  int seed = 47;
  int cnt, miscompares, n_compared;

  efc_fifo efc_fifo_inst (.mclk(mclk), .rst(rst), .wr_req(wr_req), .rd_en(rd_en), .tp_thr(tp), .bus(bus),
    .bus_rdata(bus_rdata), .rd_data(rd_data), .rd_valid(rd_valid), .flags(flags), .irq(irq));
  efc_user efc_user_inst (.mclk(mclk), .rst(rst), .go_wr(go_wr), .go_rd(go_rd), .din(din),
    .wr_req(wr_req), .rd_en(rd_en));

  // ----
  // Tasks
  // ----
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task summarize;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task bw(input logic [7:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
    @(posedge mclk);
  endtask
  task br(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    bq.push_back({m, v});
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    @(posedge mclk);
  endtask
  task push(input logic [8:0] d);
    go_wr <= 1'b1;
    din <= d;
    if (cnt < 512 || wrap_w) begin
      mem[wp] = d;
      wp++;
      if (cnt < 512) cnt++;
    end
    @(posedge mclk);
  endtask
  task pop;
    go_rd <= 1'b1;
    if (cnt > 0 || wrap_r) begin
      q.push_back(mem[rp]);
      rp++;
      if (cnt > 0) cnt--;
    end
    @(posedge mclk);
  endtask
  task idle;
    go_wr <= 1'b0;
    go_rd <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task cf(input logic on, input int af, input int ae);
    cmp("flags", {28'h000_0000, cnt == 512, cnt == 0, on && cnt >= af, on && cnt <= ae}, {28'h000_0000, flags});
  endtask

  // ----
  // Monitor
  // ----
  always @(posedge mclk) brd <= bus.rd;
  always @(negedge mclk) begin
    if (rd_valid === 1'b1 && q.size() == 0) cmp("rd_valid", 0, 1);
    else if (rd_valid === 1'b1) cmp("rd_data", 32'(q.pop_front()), 32'(rd_data));
    if (brd === 1'b1) begin
      be = bq.pop_front();
      cmp("bus_rdata", be[31:0], bus_rdata & be[63:32]);
    end
  end

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Whole run needs about 1150 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    summarize;
  end

  initial begin
    {rst, go_wr, go_rd, wrap_w, wrap_r, din, wp, rp} = '1;
    {go_wr, go_rd, wrap_w, wrap_r, din, wp, rp} = '0;
    {cnt, miscompares, n_compared} = '0;
    bus = '0;
    tp = '0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    br(8'h00, '1, 32'h0000_0001);
    br(8'h04, '1, 32'h0010_01f0);
    br(8'h08, '1, 0);
    br(8'h0c, '1, 0);
    br(8'h10, '1, 0);
    br(8'h14, '1, 0);
    cf(0, 0, 0);
    $display("test reset done");
    for (int i = 0; i < 512; i++) push(9'($random(seed)));
    idle;
    cf(0, 0, 0);
    br(8'h10, '1, 32'h0000_0200);
    br(8'h08, '0, 0);
    push(9'($random(seed)));
    idle;
    cmp("irq", 0, irq);
    bw(8'h0c, 32'h0000_0010);
    idle;
    cmp("irq", 1, irq);
    br(8'h08, 32'h0000_0010, 32'h0000_0010);
    idle;
    cmp("irq", 0, irq);
    wrap_w = 1'b1;
    bw(8'h00, 32'h0000_0009);
    repeat (3) push(9'($random(seed)));
    idle;
    cf(0, 0, 0);
    br(8'h08, 32'h0000_0010, 0);
    repeat (512) pop;
    idle;
    cf(0, 0, 0);
    $display("test full done");
    wrap_r = 1'b1;
    bw(8'h00, 32'h0000_0011);
    repeat (4) pop;
    idle;
    cf(0, 0, 0);
    {wrap_w, wrap_r} = '0;
    bw(8'h00, 32'h0000_0001);
    br(8'h08, '0, 0);
    pop;
    idle;
    br(8'h08, 32'h0000_0020, 32'h0000_0020);
    $display("test wrap done");
    bw(8'h00, 32'h0000_0004);
    bw(8'h04, 32'h0001_0003);
    repeat (3) push(9'($random(seed)));
    idle;
    cf(1, 3, 1);
    tp <= '{load: 1'b1, afull: 10'h00a, aempty: 10'h005};
    @(posedge mclk);
    tp <= '0;
    idle;
    cf(1, 10, 5);
    bw(8'h00, 32'h0000_0002);
    idle;
    cf(1, 448, 64);
    bw(8'h04, 32'h0001_0001);
    idle;
    cf(1, 448, 64);
    bw(8'h00, 32'h0000_0001);
    idle;
    cf(0, 0, 0);
    repeat (3) pop;
    idle;
    $display("test modes done");
    summarize;
  end
endmodule
